// *** rtl/tdct_pkg.sv ***
// Package with register map, field layout and timing constants of the triple timer block.
package tdct_pkg;
	localparam int          ADDR_W        = 8;
	localparam logic [7:0]  OFF_T1_DATA   = 8'h00;
	localparam logic [7:0]  OFF_T1_CTRL   = 8'h04;
	localparam logic [7:0]  OFF_T2_DATA   = 8'h08;
	localparam logic [7:0]  OFF_T2_CTRL   = 8'h0C;
	localparam logic [7:0]  OFF_T3_LOAD   = 8'h10;
	localparam logic [7:0]  OFF_T3_VALUE  = 8'h14;
	localparam logic [7:0]  OFF_T3_CTRL   = 8'h18;
	localparam logic [7:0]  OFF_T3_CLEAR  = 8'h1C;
	localparam logic [7:0]  OFF_T1_CLEAR  = 8'h20;
	localparam logic [7:0]  OFF_T2_CLEAR  = 8'h24;
	localparam logic [7:0]  OFF_SYSCTL    = 8'h28;
	localparam logic [7:0]  OFF_IRQ_STAT  = 8'h2C;
	localparam logic [7:0]  OFF_IRQ_CLR   = 8'h30;
	localparam logic [7:0]  OFF_IRQ_EN    = 8'h34;
	// Control register fields (timer 3 control, and per-timer system control bits).
	localparam int          CTL_EN_BIT    = 0;
	localparam int          CTL_PER_BIT   = 1;
	localparam int          CTL_SLOW_BIT  = 2;
	// System control register: timer 1 fields at bits 2:0, timer 2 at bits 5:3.
	localparam int          SYS_T2_SHIFT  = 3;
	localparam logic [15:0] WRAP_VALUE    = 16'hFFFF;
	localparam logic [15:0] ZERO_VALUE    = 16'h0000;
	localparam logic [2:0]  CTL_RESET     = 3'h0;
	localparam logic [2:0]  IRQ_EN_RESET  = 3'h7;
	// Count clock rates and derived divider ratios at the 25 MHz system clock.
	localparam int          PCLK_HZ       = 25_000_000;
	localparam int          FAST_SRC_HZ   = 508_000;
	localparam int          SLOW_SRC_HZ   = 2_000;
	localparam int          T3_SRC_HZ     = 7_372_800;
	localparam int          FAST_DIV      = PCLK_HZ / FAST_SRC_HZ;
	localparam int          SLOW_DIV      = PCLK_HZ / SLOW_SRC_HZ;
	localparam int          DIV_W         = 14;
	// Fractional accumulator for the 7.3728 MHz tick, steps of 100 Hz.
	localparam int          T3_UNIT_HZ    = 100;
	localparam logic [17:0] T3_STEP       = 18'(T3_SRC_HZ / T3_UNIT_HZ);
	localparam logic [17:0] T3_MOD        = 18'(PCLK_HZ / T3_UNIT_HZ);
	typedef struct packed {
		logic slow_sel;
		logic periodic;
		logic enable;
	} tdct_ctl_t;
	typedef struct packed {
		logic        load;
		logic [15:0] value;
		logic        clear;
	} tdct_wr_t;
endpackage

// *** rtl/tdct_counter.sv ***
// One 16-bit down counter with load, free-running or periodic reload, and sticky underflow.
`timescale 1ns/10ps
module tdct_counter (
	input  wire logic                pclk,    // System clock.
	input  wire logic                presetn, // Asynchronous reset, active low.
	input  wire tdct_pkg::tdct_ctl_t ctl,     // Enable and mode.
	input  wire tdct_pkg::tdct_wr_t  wr,      // Load and clear strobes.
	input  wire logic                tick,    // One-cycle count clock enable.
	output logic [15:0]              count,   // Current count.
	output logic                     irq      // Underflow interrupt level.
);
	logic [15:0] count_q, count_d;
	logic [15:0] reload_q;
	logic        irq_q;
	logic        step;
	logic        under;

	assign step  = tick & ctl.enable;
	assign under = step & (count_q == tdct_pkg::ZERO_VALUE);
	assign count_d = wr.load ? wr.value :
		!step ? count_q :
		!under ? count_q - 16'h0001 :
		ctl.periodic ? reload_q : tdct_pkg::WRAP_VALUE;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_q  <= tdct_pkg::ZERO_VALUE;
			reload_q <= tdct_pkg::ZERO_VALUE;
		end else begin
			count_q <= count_d;
			if (wr.load) begin
				reload_q <= wr.value;
			end
		end
	end

	// Underflow wins over a clear arriving in the same cycle.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_q <= 1'b0;
		end else if (under) begin
			irq_q <= 1'b1;
		end else if (wr.clear) begin
			irq_q <= 1'b0;
		end
	end

	assign count = count_q;
	assign irq   = irq_q | under;
endmodule // tdct_counter

// *** rtl/tdct_top.sv ***
// Triple down counter timer block with APB register access and combined interrupt.
//
// Register access over APB and the register offsets were left to the implementer.
`timescale 1ns/10ps
module tdct_top (
	input  wire logic        pclk,      // APB clock, 25 MHz.
	input  wire logic        presetn,   // Asynchronous reset, active low.
	input  wire logic        psel,      // APB select.
	input  wire logic        penable,   // APB access phase.
	input  wire logic        pwrite,    // APB write.
	input  wire logic [7:0]  paddr,     // APB byte address.
	input  wire logic [31:0] pwdata,    // APB write data.
	output logic [31:0]      prdata,    // APB read data.
	output logic             pready,    // APB ready.
	output logic             pslverr,   // APB error on unmapped address.
	output logic [2:0]       timer_irq, // Per-timer underflow interrupts.
	output logic             irq        // Combined enabled interrupt.
);
	localparam int DIVW = tdct_pkg::DIV_W;

	logic              wr_en;
	logic              rd_en;
	logic              mapped;
	logic [5:0]        sysctl_q;
	logic [2:0]        t3ctl_q;
	logic [2:0]        irq_en_q;
	logic [2:0]        irq_stat_q;
	logic [DIVW-1:0]   fast_cnt_q;
	logic [DIVW-1:0]   slow_cnt_q;
	logic [17:0]       t3_acc_q;
	logic              fast_tick;
	logic              slow_tick;
	logic              t3_tick;
	logic [18:0]       t3_acc_sum;
	logic [15:0]       cnt [3];
	logic [2:0]        tick;
	logic [31:0]       rdata_d;
	logic [31:0]       prdata_q;
	tdct_pkg::tdct_ctl_t ctl [3];
	tdct_pkg::tdct_wr_t  wr  [3];

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction

	assign wr_en  = psel & penable & pwrite;
	assign rd_en  = psel & ~penable & ~pwrite;
	assign pready = 1'b1;
	assign mapped = (paddr <= tdct_pkg::OFF_IRQ_EN) & (paddr[1:0] == 2'h0);
	assign pslverr = psel & penable & ~mapped;

	// Dividers turn the system clock into count clock enable pulses.
	assign fast_tick = (fast_cnt_q == DIVW'(tdct_pkg::FAST_DIV - 1));
	assign slow_tick = (slow_cnt_q == DIVW'(tdct_pkg::SLOW_DIV - 1));
	// One spare bit keeps the sum from wrapping before it is compared with the modulus.
	assign t3_acc_sum = {1'b0, t3_acc_q} + {1'b0, tdct_pkg::T3_STEP};
	assign t3_tick = (t3_acc_sum >= {1'b0, tdct_pkg::T3_MOD});

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fast_cnt_q <= '0;
			slow_cnt_q <= '0;
			t3_acc_q   <= '0;
		end else begin
			fast_cnt_q <= fast_tick ? '0 : fast_cnt_q + 1'b1;
			slow_cnt_q <= slow_tick ? '0 : slow_cnt_q + 1'b1;
			t3_acc_q   <= t3_tick ? 18'(t3_acc_sum - {1'b0, tdct_pkg::T3_MOD}) : t3_acc_sum[17:0];
		end
	end

	// Per-timer controls: timers 1 and 2 from system control, timer 3 from its own.
	assign ctl[0] = sysctl_q[2:0];
	assign ctl[1] = sysctl_q[5:3];
	assign ctl[2] = '{slow_sel: 1'b0, periodic: t3ctl_q[tdct_pkg::CTL_PER_BIT],
		enable: t3ctl_q[tdct_pkg::CTL_EN_BIT]};
	assign tick[0] = ctl[0].slow_sel ? slow_tick : fast_tick;
	assign tick[1] = ctl[1].slow_sel ? slow_tick : fast_tick;
	assign tick[2] = t3_tick;

	assign wr[0] = '{load: wr_en & hit(paddr, tdct_pkg::OFF_T1_DATA), value: pwdata[15:0],
		clear: wr_en & hit(paddr, tdct_pkg::OFF_T1_CLEAR)};
	assign wr[1] = '{load: wr_en & hit(paddr, tdct_pkg::OFF_T2_DATA), value: pwdata[15:0],
		clear: wr_en & hit(paddr, tdct_pkg::OFF_T2_CLEAR)};
	assign wr[2] = '{load: wr_en & hit(paddr, tdct_pkg::OFF_T3_LOAD), value: pwdata[15:0],
		clear: wr_en & hit(paddr, tdct_pkg::OFF_T3_CLEAR)};

	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_tmr
			tdct_counter u_cnt (
				.pclk    (pclk),
				.presetn (presetn),
				.ctl     (ctl[g]),
				.wr      (wr[g]),
				.tick    (tick[g]),
				.count   (cnt[g]),
				.irq     (timer_irq[g])
			);
		end
	endgenerate

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sysctl_q <= {tdct_pkg::CTL_RESET, tdct_pkg::CTL_RESET};
			t3ctl_q  <= tdct_pkg::CTL_RESET;
			irq_en_q <= tdct_pkg::IRQ_EN_RESET;
		end else if (wr_en) begin
			if (hit(paddr, tdct_pkg::OFF_SYSCTL)) begin
				sysctl_q <= pwdata[5:0];
			end
			if (hit(paddr, tdct_pkg::OFF_T1_CTRL)) begin
				sysctl_q[2:0] <= pwdata[2:0];
			end
			if (hit(paddr, tdct_pkg::OFF_T2_CTRL)) begin
				sysctl_q[5:3] <= pwdata[2:0];
			end
			if (hit(paddr, tdct_pkg::OFF_T3_CTRL)) begin
				t3ctl_q <= pwdata[2:0];
			end
			if (hit(paddr, tdct_pkg::OFF_IRQ_EN)) begin
				irq_en_q <= pwdata[2:0];
			end
		end
	end

	// Status bits are set by underflow; a set beats a clear in the same cycle.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat_q <= '0;
		end else begin
			irq_stat_q <= timer_irq |
				(irq_stat_q & ~(wr_en & hit(paddr, tdct_pkg::OFF_IRQ_CLR) ? pwdata[2:0] : 3'h0));
		end
	end

	assign irq = |(irq_stat_q & irq_en_q);

	// Read data is registered in the setup cycle and shown in the access phase.
	always_comb begin
		rdata_d = 32'h0;
		case (paddr)
			tdct_pkg::OFF_T1_DATA:  rdata_d = {16'h0, cnt[0]};
			tdct_pkg::OFF_T2_DATA:  rdata_d = {16'h0, cnt[1]};
			tdct_pkg::OFF_T3_VALUE: rdata_d = {16'h0, cnt[2]};
			tdct_pkg::OFF_T3_LOAD:  rdata_d = {16'h0, cnt[2]};
			tdct_pkg::OFF_T1_CTRL:  rdata_d = {29'h0, sysctl_q[2:0]};
			tdct_pkg::OFF_T2_CTRL:  rdata_d = {29'h0, sysctl_q[5:3]};
			tdct_pkg::OFF_T3_CTRL:  rdata_d = {29'h0, t3ctl_q};
			tdct_pkg::OFF_SYSCTL:   rdata_d = {26'h0, sysctl_q};
			tdct_pkg::OFF_IRQ_STAT: rdata_d = {29'h0, irq_stat_q};
			tdct_pkg::OFF_IRQ_EN:   rdata_d = {29'h0, irq_en_q};
			default:                rdata_d = 32'h0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h0;
		end else if (rd_en) begin
			prdata_q <= rdata_d;
		end
	end

	assign prdata = prdata_q;
endmodule // tdct_top

// *** tb/tdct_assertions.sv ***
// Port checker for the triple timer block.
`timescale 1ns/10ps
module tdct_assertions (
	input wire logic        pclk,      // Clock.
	input wire logic        presetn,   // Reset.
	input wire logic        psel,      // Select.
	input wire logic        penable,   // Access.
	input wire logic        pwrite,    // Write.
	input wire logic [7:0]  paddr,     // Address.
	input wire logic [31:0] pwdata,    // Write data.
	input wire logic [31:0] prdata,    // Read data.
	input wire logic        pready,    // Ready.
	input wire logic        pslverr,   // Error.
	input wire logic [2:0]  timer_irq, // Timer interrupts.
	input wire logic        irq        // Combined interrupt.
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire acc = psel && penable;
	wire bad = paddr > 8'h34 || paddr[1:0] != 2'h0;
	wire en_off = acc && pwrite && paddr == tdct_pkg::OFF_IRQ_EN && pwdata[2:0] == 3'h0;
	wire en_wr = acc && pwrite && paddr == tdct_pkg::OFF_IRQ_EN;
	property p_ready; pready; endproperty
	property p_err; acc && bad |-> pslverr; endproperty
	property p_noerr; acc && !bad |-> !pslverr; endproperty
	property p_rd_zero; acc && !pwrite && bad |-> prdata == 32'h0; endproperty
	property p_rd_hold; !(psel && !penable) |=> $stable(prdata); endproperty
	property p_stick(int b, logic [7:0] a);
		timer_irq[b] && !(acc && pwrite && paddr == a) |=> timer_irq[b];
	endproperty
	property p_mask; en_off |=> ##1 !irq; endproperty
	property p_rise;
		$rose(irq) |-> $past(timer_irq) != 3'h0 || $past(timer_irq, 2) != 3'h0 || $past(en_wr);
	endproperty
	a_ready: assert property (p_ready) else $error("pready low");
	a_err: assert property (p_err) else $error("no error on unmapped");
	a_noerr: assert property (p_noerr) else $error("error on mapped");
	a_rd_zero: assert property (p_rd_zero) else $error("unmapped read not zero");
	a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
	a_stick_t1: assert property (p_stick(0, tdct_pkg::OFF_T1_CLEAR)) else $error("t1 irq");
	a_stick_t2: assert property (p_stick(1, tdct_pkg::OFF_T2_CLEAR)) else $error("t2 irq");
	a_stick_t3: assert property (p_stick(2, tdct_pkg::OFF_T3_CLEAR)) else $error("t3 irq");
	a_mask: assert property (p_mask) else $error("irq not masked");
	a_rise: assert property (p_rise) else $error("irq without source");
	c_t3: cover property (timer_irq[2]);
	c_err: cover property (acc && pslverr);
	c_mask: cover property (en_off);
endmodule // tdct_assertions
bind tdct_top tdct_assertions u_tdct_assertions (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .timer_irq(timer_irq), .irq(irq));

// *** tb/tdct_top_tb.sv ***
// Self-checking bench for the triple timer block.
`timescale 1ns/10ps
module tdct_top_tb;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, e;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, r;
	logic [2:0]  timer_irq;
	int          n_mismatch = 0;
	int          n_checks = 0;
	tdct_top u_tdct_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .timer_irq(timer_irq), .irq(irq));
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wirq(input int b, input int lim);
		int k;
		k = 0;
		while (timer_irq[b] !== 1'b1 && k < lim) begin
			@(negedge pclk);
			k++;
		end
		chk("timer_irq", {31'h0, timer_irq[b]}, 32'h1);
	endtask
	task automatic test_done;
		if (n_mismatch == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	initial begin
		#800000;
		n_mismatch++;
		test_done;
	end
	initial begin
		presetn = 1'b0;
		psel    = 1'b0;
		penable = 1'b0;
		pwrite  = 1'b0;
		paddr   = 8'h00;
		pwdata  = 32'h0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		xfer(1'b0, tdct_pkg::OFF_SYSCTL, 32'h0);
		chk("sysctl", r, 32'h0);
		xfer(1'b0, tdct_pkg::OFF_IRQ_EN, 32'h0);
		chk("irq_en", r, 32'h7);
		xfer(1'b1, tdct_pkg::OFF_T1_DATA, 32'h1234_0005);
		repeat (60) @(posedge pclk);
		xfer(1'b0, tdct_pkg::OFF_T1_DATA, 32'h0);
		chk("t1_data", r, 32'h5);
		xfer(1'b0, 8'h38, 32'h0);
		chk("slverr", {31'h0, e}, 32'h1);
		xfer(1'b1, tdct_pkg::OFF_T3_LOAD, 32'h3);
		xfer(1'b1, tdct_pkg::OFF_T3_CTRL, 32'h1);
		wirq(2, 100);
		xfer(1'b0, tdct_pkg::OFF_IRQ_STAT, 32'h0);
		chk("stat", r, 32'h4);
		chk("irq", {31'h0, irq}, 32'h1);
		xfer(1'b1, tdct_pkg::OFF_IRQ_EN, 32'h0);
		repeat (2) @(negedge pclk);
		chk("irq", {31'h0, irq}, 32'h0);
		xfer(1'b1, tdct_pkg::OFF_IRQ_EN, 32'h7);
		xfer(1'b1, tdct_pkg::OFF_T3_CTRL, 32'h0);
		xfer(1'b0, tdct_pkg::OFF_T3_VALUE, 32'h0);
		chk("t3_wrap", {24'h0, r[15:8]}, 32'hFF);
		xfer(1'b1, tdct_pkg::OFF_T3_CLEAR, 32'h0);
		@(negedge pclk);
		chk("t3_irq", {31'h0, timer_irq[2]}, 32'h0);
		xfer(1'b1, tdct_pkg::OFF_IRQ_CLR, 32'h7);
		xfer(1'b0, tdct_pkg::OFF_IRQ_STAT, 32'h0);
		chk("stat", r, 32'h0);
		xfer(1'b1, tdct_pkg::OFF_T3_LOAD, 32'h4);
		xfer(1'b1, tdct_pkg::OFF_T3_CTRL, 32'h3);
		wirq(2, 100);
		xfer(1'b1, tdct_pkg::OFF_T3_CTRL, 32'h0);
		xfer(1'b0, tdct_pkg::OFF_T3_VALUE, 32'h0);
		chk("t3_reload", {19'h0, r[15:3]}, 32'h0);
		xfer(1'b1, tdct_pkg::OFF_T1_DATA, 32'h2);
		xfer(1'b1, tdct_pkg::OFF_SYSCTL, 32'h3);
		wirq(0, 300);
		xfer(1'b1, tdct_pkg::OFF_T2_DATA, 32'h0);
		xfer(1'b1, tdct_pkg::OFF_SYSCTL, 32'h28);
		xfer(1'b1, tdct_pkg::OFF_T1_CLEAR, 32'h0);
		@(negedge pclk);
		chk("t1_irq", {31'h0, timer_irq[0]}, 32'h0);
		wirq(1, 13000);
		xfer(1'b0, tdct_pkg::OFF_T2_DATA, 32'h0);
		chk("t2_wrap", r, 32'hFFFF);
		xfer(1'b1, tdct_pkg::OFF_T2_DATA, 32'h3);
		xfer(1'b0, tdct_pkg::OFF_T2_DATA, 32'h0);
		chk("t2_load", r, 32'h3);
		test_done;
	end
endmodule // tdct_top_tb
